// >>> logic/legacy_isa_bridge_config_regs.sv
// Notes on behaviour
// - Slow clock from reference clock, internal or driven out, or from external input; code 11 is invalid.
// - Disk controller reset bit held high keeps both controllers in reset.
// - Disk bus reset bit high asserts disk bus reset until cleared.
// - PCI reset bit asserts PCI bus reset only; software clears it.
// - Warm start bit reads 0 after a warm start, 1 if none.
// - Writing 1 to warm start bit fires system reset; 0 does nothing.
// - Timer reset bit 1 holds interval timer in reset.
// - Channel 1 gate follows its control bit.
// - Channel 0 pass bit 0 forces zero, 1 drives interrupt line zero.
// - Channel 0 gate follows its control bit.
// - Divisor field divides PCI clock for ISA clock; 000 reserved; the logic holds the clock low for codes four and above.
// - 16-bit I/O recovery is low nibble plus one plus one.
// - A20 snoop enable lets device snoop keyboard A20 commands.
// - Separate enables for game port chip select on reads and writes.
// - When enabled, warm reset forces A20 mask deasserted.
// - Port 092h decode only when its enable bit is set.
// - Two range bits enlarge upper and low boot ROM windows.
// - Optional boot ROM chip select on writes to ROM space.
// - Block bit suppresses ISA cycle for game port writes.
`timescale 1ns/1ps
`default_nettype none
module legacy_isa_bridge_config_regs
  import legacy_cfg_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic reference_clock_in,
  input wire logic slow_clock_in,
  output logic slow_clock_pin,
  output logic slow_clock_oe,
  output logic slow_clock,
  output logic disk_ctrl_rst,
  output logic disk_bus_rst,
  output logic pci_bus_rst,
  output logic system_rst_pulse,
  input wire logic warm_reset_seen,
  output logic interval_timer_rst,
  input wire logic timer_ch1_output,
  input wire logic timer_ch0_output,
  output logic timer_ch1_gate,
  output logic timer_ch0_gate,
  output logic port61_bit4,
  output logic interrupt_line_zero,
  output logic isa_clk,
  input wire logic isa_io_busy_end,
  input wire logic isa_io_is_16,
  output logic isa_io_recovering,
  input wire logic kbd_a20_cmd,
  input wire logic kbd_a20_value,
  output logic a20_snoop_en,
  output logic addr_line20_mask,
  input wire legacy_cfg_pkg::isa_cycle_t isa_cycle,
  output legacy_cfg_pkg::decode_t isa_decode,
  output logic game_port_chip_select_n,
  output logic boot_rom_chip_select_n
);
  import legacy_cfg_pkg::*;

  ////////////////////////////////////////////////////////////////////
  logic [7:0] reset_ctrl_reg;
  logic [7:0] timer_ctrl_reg;
  logic [7:0] io_recovery_reg;
  logic [7:0] rom_legacy_reg;
  logic [7:0] alt_cpu_reg;
  logic no_warm_reg;
  logic sys_rst_pulse_reg;
  logic [7:0] rdata_reg;

  wire hit_rc = reg_addr == OFF_RESET_CTRL;
  wire hit_tc = reg_addr == OFF_TIMER_CTRL;
  wire hit_io = reg_addr == OFF_IO_RECOVERY;
  wire hit_rl = reg_addr == OFF_ROM_LEGACY;
  wire hit_ac = reg_addr == OFF_ALT_CPU;
  wire warm_write = reg_wr && hit_rc && reg_wdata[RC_WARM_START];

  wire [7:0] rc_view = {reset_ctrl_reg[7:1], no_warm_reg};
  wire [7:0] rd_mux = hit_rc ? rc_view :
                      hit_tc ? timer_ctrl_reg :
                      hit_io ? io_recovery_reg :
                      hit_rl ? rom_legacy_reg :
                      hit_ac ? alt_cpu_reg : 8'h00;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      reset_ctrl_reg <= RST_RESET_CTRL;
      timer_ctrl_reg <= RST_TIMER_CTRL;
      io_recovery_reg <= RST_IO_RECOVERY;
      rom_legacy_reg <= RST_ROM_LEGACY;
      alt_cpu_reg <= RST_ALT_CPU;
    end else if (reg_wr) begin
      // level bits held until software clears
      if (hit_rc) begin
        reset_ctrl_reg <= {reg_wdata[7:1], 1'b0};
      end
      if (hit_tc) begin
        timer_ctrl_reg <= reg_wdata;
      end
      if (hit_io) begin
        io_recovery_reg <= reg_wdata;
      end
      if (hit_rl) begin
        rom_legacy_reg <= reg_wdata;
      end
      if (hit_ac) begin
        alt_cpu_reg <= reg_wdata & AC_WRITE_MASK;
      end
    end
  end

  // warm start status, sticky; power-on only clears it
  // write of 1 pulses system reset
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      no_warm_reg <= 1'b1;
      sys_rst_pulse_reg <= 1'b0;
      rdata_reg <= 8'h00;
    end else begin
      if (warm_reset_seen || warm_write) begin
        no_warm_reg <= 1'b0;
      end
      sys_rst_pulse_reg <= warm_write;
      rdata_reg <= reg_rd ? rd_mux : 8'h00;
    end
  end
  assign reg_rdata = rdata_reg;
  assign system_rst_pulse = sys_rst_pulse_reg;

  ////////////////////////////////////////////////////////////////////
  // reset outputs
  assign disk_ctrl_rst = reset_ctrl_reg[RC_DISK_CTRL_RST];
  assign disk_bus_rst = reset_ctrl_reg[RC_DISK_BUS_RST];
  assign pci_bus_rst = reset_ctrl_reg[RC_PCI_RST];

  // slow clock source; reference input is taken as synchronous
  wire [1:0] slow_sel = reset_ctrl_reg[RC_SLOW_CLK_LO +: 2];
  logic [7:0] ref_cnt_reg;
  logic ref_prev_reg;
  logic slow_int_reg;
  wire ref_rise = reference_clock_in && !ref_prev_reg;
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ref_cnt_reg <= 8'h00;
      ref_prev_reg <= 1'b0;
      slow_int_reg <= 1'b0;
    end else begin
      ref_prev_reg <= reference_clock_in;
      if (ref_rise) begin
        if (ref_cnt_reg == 8'(REF_HALF_PERIOD - 1)) begin
          ref_cnt_reg <= 8'h00;
          slow_int_reg <= ~slow_int_reg;
        end else begin
          ref_cnt_reg <= ref_cnt_reg + 8'h01;
        end
      end
    end
  end
  // Invalid code gives no clock rather than a guess
  assign slow_clock = (slow_sel == SLOW_EXTERNAL) ? slow_clock_in :
                      (slow_sel == SLOW_INVALID) ? 1'b0 : slow_int_reg;
  assign slow_clock_oe = slow_sel == SLOW_INT_DRIVEN;
  assign slow_clock_pin = slow_int_reg;

  ////////////////////////////////////////////////////////////////////
  // timer reset, gates and output pass bits
  assign interval_timer_rst = timer_ctrl_reg[TC_TIMER_RST];
  assign port61_bit4 = timer_ctrl_reg[TC_CH1_PASS] & timer_ch1_output;
  assign timer_ch1_gate = timer_ctrl_reg[TC_CH1_GATE];
  assign interrupt_line_zero = timer_ctrl_reg[TC_CH0_PASS] & timer_ch0_output;
  assign timer_ch0_gate = timer_ctrl_reg[TC_CH0_GATE];

  ////////////////////////////////////////////////////////////////////
  // ISA clock divider; reserved code and codes four and above hold the clock low
  wire [2:0] div_code = timer_ctrl_reg[TC_DIV_LO +: 3];
  wire div_ok = (div_code != DIV_RESERVED) && !div_code[2];
  logic [2:0] div_cnt_reg;
  logic isa_clk_reg;
  logic isa_rise_reg;
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      div_cnt_reg <= 3'h0;
      isa_clk_reg <= 1'b0;
      isa_rise_reg <= 1'b0;
    end else if (!div_ok) begin
      div_cnt_reg <= 3'h0;
      isa_clk_reg <= 1'b0;
      isa_rise_reg <= 1'b0;
    end else if (div_cnt_reg >= div_code) begin
      div_cnt_reg <= 3'h0;
      isa_clk_reg <= 1'b1;
      isa_rise_reg <= 1'b1;
    end else begin
      div_cnt_reg <= div_cnt_reg + 3'h1;
      isa_rise_reg <= 1'b0;
      if (div_cnt_reg == {1'b0, div_code[2:1]}) begin
        isa_clk_reg <= 1'b0;
      end
    end
  end
  assign isa_clk = isa_clk_reg;

  // recovery: field plus one, plus the fixed clock
  logic [4:0] rec_cnt_reg;
  wire [3:0] rec_field = isa_io_is_16 ? io_recovery_reg[3:0] : io_recovery_reg[7:4];
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rec_cnt_reg <= 5'h00;
    end else if (isa_io_busy_end) begin
      rec_cnt_reg <= {1'b0, rec_field} + 5'h02;
    end else if (isa_rise_reg && rec_cnt_reg != 5'h00) begin
      rec_cnt_reg <= rec_cnt_reg - 5'h01;
    end
  end
  assign isa_io_recovering = rec_cnt_reg != 5'h00;

  ////////////////////////////////////////////////////////////////////
  // snoop enable and A20 mask
  assign a20_snoop_en = rom_legacy_reg[RL_A20_SNOOP];
  logic a20_reg;
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      a20_reg <= 1'b0;
    end else if (warm_reset_seen && rom_legacy_reg[RL_A20_WARM_CLR]) begin
      a20_reg <= 1'b0;
    end else if (kbd_a20_cmd && rom_legacy_reg[RL_A20_SNOOP]) begin
      a20_reg <= kbd_a20_value;
    end
  end
  assign addr_line20_mask = a20_reg;

  // Address decode
  wire game_hit = isa_cycle.valid && isa_cycle.is_io &&
                  (isa_cycle.addr[15:0] == GAME_PORT_LO || isa_cycle.addr[15:0] == GAME_PORT_HI);
  wire game_cs = game_hit && (isa_cycle.write ? rom_legacy_reg[RL_GAME_WR_CS] : rom_legacy_reg[RL_GAME_RD_CS]);
  wire p92_hit = isa_cycle.valid && isa_cycle.is_io && rom_legacy_reg[RL_PORT92_EN] &&
                 isa_cycle.addr[15:0] == PORT_92;
  wire [7:0] hi_byte = isa_cycle.addr[23:16];
  wire up_win = rom_legacy_reg[RL_ROM_UPPER] ? (hi_byte >= ROM_UP_BIG - 8'h0f) : (hi_byte >= ROM_UP_DEF);
  wire low_win = rom_legacy_reg[RL_ROM_LOW] ? (hi_byte == ROM_LOW_BIG || hi_byte == ROM_LOW_DEF) :
                 (hi_byte == ROM_LOW_DEF);
  // writes to ROM only when enabled
  wire rom_cs = isa_cycle.valid && !isa_cycle.is_io && (up_win || low_win) &&
                (!isa_cycle.write || rom_legacy_reg[RL_ROM_WRITE]);
  wire blk = game_hit && isa_cycle.write && alt_cpu_reg[AC_GAME_WR_BLOCK];

  assign isa_decode = '{rom_cs: rom_cs, game_cs: game_cs, port92_hit: p92_hit, isa_block: blk};
  assign game_port_chip_select_n = ~game_cs;
  assign boot_rom_chip_select_n = ~rom_cs;

  ////////////////////////////////////////////////////////////////////
  // pulse follows a one write
  chk_warm_pulse: assert property (
    @(posedge mclk) disable iff (sys_rst)
    warm_write |=> system_rst_pulse && !no_warm_reg)
    else $error("warm start pulse missing");
  chk_warm_sticky: assert property (
    @(posedge mclk) disable iff (sys_rst)
    !no_warm_reg |=> !no_warm_reg)
    else $error("warm status cleared");
  chk_read_timing: assert property (
    @(posedge mclk) disable iff (sys_rst)
    reg_rd && hit_tc |=> reg_rdata == $past(timer_ctrl_reg))
    else $error("read data wrong");
  chk_pci_reset: assert property (
    @(posedge mclk) disable iff (sys_rst)
    reg_wr && hit_rc |=> pci_bus_rst == $past(reg_wdata[RC_PCI_RST]))
    else $error("pci reset bad");
  chk_interrupt_line_zero_gate: assert property (
    @(posedge mclk) disable iff (sys_rst)
    !timer_ctrl_reg[TC_CH0_PASS] |-> !interrupt_line_zero)
    else $error("interrupt_line_zero leaked");
  chk_a20_clear: assert property (
    @(posedge mclk) disable iff (sys_rst)
    warm_reset_seen && rom_legacy_reg[RL_A20_WARM_CLR] |=> !addr_line20_mask)
    else $error("a20 held");
  chk_game_block: assert property (
    @(posedge mclk) disable iff (sys_rst)
    isa_decode.isa_block |-> isa_cycle.write && alt_cpu_reg[AC_GAME_WR_BLOCK])
    else $error("bad block");
  chk_recovery_load: assert property (
    @(posedge mclk) disable iff (sys_rst)
    isa_io_busy_end && isa_io_is_16 |=> rec_cnt_reg == {1'b0, $past(io_recovery_reg[3:0])} + 5'h02)
    else $error("recovery count wrong");
  chk_recovery_8bit: assert property (
    @(posedge mclk) disable iff (sys_rst)
    isa_io_busy_end && !isa_io_is_16 |=> rec_cnt_reg == {1'b0, $past(io_recovery_reg[7:4])} + 5'h02)
    else $error("byte recovery count wrong");
  chk_disk_ctrl_rst: assert property (
    @(posedge mclk) disable iff (sys_rst)
    reg_wr && hit_rc |=> disk_ctrl_rst == $past(reg_wdata[RC_DISK_CTRL_RST]))
    else $error("disk controller reset bad");
  chk_disk_bus_rst: assert property (
    @(posedge mclk) disable iff (sys_rst)
    reg_wr && hit_rc |=> disk_bus_rst == $past(reg_wdata[RC_DISK_BUS_RST]))
    else $error("disk bus reset bad");
  chk_bus_rst_hold: assert property (
    @(posedge mclk) disable iff (sys_rst)
    !(reg_wr && hit_rc) |=> $stable(disk_bus_rst))
    else $error("disk bus reset moved");
  chk_timer_rst: assert property (
    @(posedge mclk) disable iff (sys_rst)
    reg_wr && hit_tc |=> interval_timer_rst == $past(reg_wdata[TC_TIMER_RST]))
    else $error("timer reset bad");
  chk_ch1_gate: assert property (
    @(posedge mclk) disable iff (sys_rst)
    reg_wr && hit_tc |=> timer_ch1_gate == $past(reg_wdata[TC_CH1_GATE]))
    else $error("channel 1 gate bad");
  chk_ch0_gate: assert property (
    @(posedge mclk) disable iff (sys_rst)
    reg_wr && hit_tc |=> timer_ch0_gate == $past(reg_wdata[TC_CH0_GATE]))
    else $error("channel 0 gate bad");
  chk_ch1_blocked: assert property (
    @(posedge mclk) disable iff (sys_rst)
    !timer_ctrl_reg[TC_CH1_PASS] |-> !port61_bit4)
    else $error("channel 1 output leaked");
  chk_slow_invalid: assert property (
    @(posedge mclk) disable iff (sys_rst)
    slow_sel == SLOW_INVALID |-> !slow_clock && !slow_clock_oe)
    else $error("invalid slow clock code active");
  chk_isa_stopped: assert property (
    @(posedge mclk) disable iff (sys_rst)
    !div_ok |=> !isa_clk)
    else $error("isa clock runs on bad code");
  chk_port92_off: assert property (
    @(posedge mclk) disable iff (sys_rst)
    !rom_legacy_reg[RL_PORT92_EN] |-> !isa_decode.port92_hit)
    else $error("port 092h decoded while off");
  chk_rdata_idle: assert property (
    @(posedge mclk) disable iff (sys_rst)
    !reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not idle");
  chk_snoop_off: assert property (
    @(posedge mclk) disable iff (sys_rst)
    !rom_legacy_reg[RL_A20_SNOOP] && !warm_reset_seen |=> $stable(addr_line20_mask))
    else $error("a20 moved without snoop");
endmodule : legacy_isa_bridge_config_regs
`default_nettype wire

// >>> logic/legacy_cfg_pkg.sv
`default_nettype none
package legacy_cfg_pkg;
  // Register offsets (byte addresses in configuration space)
  localparam logic [7:0] OFF_RESET_CTRL = 8'h44;
  localparam logic [7:0] OFF_TIMER_CTRL = 8'h50;
  localparam logic [7:0] OFF_IO_RECOVERY = 8'h51;
  localparam logic [7:0] OFF_ROM_LEGACY = 8'h52;
  localparam logic [7:0] OFF_ALT_CPU = 8'h53;
  // Reset values
  localparam logic [7:0] RST_RESET_CTRL = 8'h01;
  localparam logic [7:0] RST_TIMER_CTRL = 8'h7b;
  localparam logic [7:0] RST_IO_RECOVERY = 8'h40;
  localparam logic [7:0] RST_ROM_LEGACY = 8'hf8;
  localparam logic [7:0] RST_ALT_CPU = 8'h00;
  // Reset control bit positions
  localparam int RC_SLOW_CLK_LO = 4;
  localparam int RC_DISK_CTRL_RST = 3;
  localparam int RC_DISK_BUS_RST = 2;
  localparam int RC_PCI_RST = 1;
  localparam int RC_WARM_START = 0;
  // Timer control bit positions
  localparam int TC_TIMER_RST = 7;
  localparam int TC_CH1_PASS = 6;
  localparam int TC_CH1_GATE = 5;
  localparam int TC_CH0_PASS = 4;
  localparam int TC_CH0_GATE = 3;
  localparam int TC_DIV_LO = 0;
  // ROM / legacy logic bit positions
  localparam int RL_A20_SNOOP = 7;
  localparam int RL_GAME_WR_CS = 6;
  localparam int RL_GAME_RD_CS = 5;
  localparam int RL_A20_WARM_CLR = 4;
  localparam int RL_PORT92_EN = 3;
  localparam int RL_ROM_UPPER = 2;
  localparam int RL_ROM_WRITE = 1;
  localparam int RL_ROM_LOW = 0;
  // Alternate CPU support
  localparam int AC_GAME_WR_BLOCK = 6;
  localparam logic [7:0] AC_WRITE_MASK = 8'h7f;
  // Slow clock source codes
  localparam logic [1:0] SLOW_INT_HIDDEN = 2'h0;
  localparam logic [1:0] SLOW_INT_DRIVEN = 2'h1;
  localparam logic [1:0] SLOW_EXTERNAL = 2'h2;
  localparam logic [1:0] SLOW_INVALID = 2'h3;
  // Divisor code reserved value
  localparam logic [2:0] DIV_RESERVED = 3'h0;
  // Reference clock to 32 kHz half period, in reference clock edges
  localparam int REF_HALF_PERIOD = 224;
  // Game port and port 092h I/O addresses
  localparam logic [15:0] GAME_PORT_LO = 16'h0200;
  localparam logic [15:0] GAME_PORT_HI = 16'h0201;
  localparam logic [15:0] PORT_92 = 16'h0092;
  // ROM windows, decoded on address bits 23:16
  localparam logic [7:0] ROM_UP_DEF = 8'hfc;
  localparam logic [7:0] ROM_UP_BIG = 8'hff;
  localparam logic [7:0] ROM_LOW_DEF = 8'h0f;
  localparam logic [7:0] ROM_LOW_BIG = 8'h0e;
  localparam logic [7:0] ROM_TOP_BYTE = 8'hff;

  typedef struct packed {
    logic valid;
    logic write;
    logic is_io;
    logic [23:0] addr;
  } isa_cycle_t;

  typedef struct packed {
    logic rom_cs;
    logic game_cs;
    logic port92_hit;
    logic isa_block;
  } decode_t;
endpackage : legacy_cfg_pkg
`default_nettype wire

// >>> tb/legacy_peripheral_model.sv
`timescale 1ns/1ps
`default_nettype none
module legacy_peripheral_model (
  input wire logic mclk,
  input wire logic sys_rst,
  output logic reference_clock_in,
  output logic slow_clock_in,
  output logic timer_ch0_output,
  output logic timer_ch1_output
);
  logic [4:0] cnt_reg;
  ////////////////////////////////////////////////////////////////////////////
  // Unrelated toggle rates, so a stuck gate or swapped channel shows
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_reg <= 5'h00;
    end else begin
      cnt_reg <= cnt_reg + 5'h01;
    end
  end
  assign reference_clock_in = cnt_reg[0];
  assign slow_clock_in = cnt_reg[4];
  assign timer_ch0_output = cnt_reg[1];
  assign timer_ch1_output = cnt_reg[2] ^ cnt_reg[0];
endmodule : legacy_peripheral_model
`default_nettype wire

// >>> tb/legacy_isa_bridge_config_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module legacy_isa_bridge_config_regs_tb;
  import legacy_cfg_pkg::*;
  typedef struct packed {
    logic [7:0] a;
    logic [7:0] d;
    logic [7:0] e;
    isa_cycle_t c;
    logic [3:0] x;
  } row_t;
  logic mclk, sys_rst, reg_wr, reg_rd, reference_clock_in, slow_clock_in, slow_clock_pin, slow_clock_oe, slow_clock;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, q;
  logic disk_ctrl_rst, disk_bus_rst, pci_bus_rst, system_rst_pulse, warm_reset_seen, interval_timer_rst;
  logic timer_ch1_output, timer_ch0_output, timer_ch1_gate, timer_ch0_gate, port61_bit4, interrupt_line_zero;
  logic isa_clk, isa_io_busy_end, isa_io_is_16, isa_io_recovering, kbd_a20_cmd, kbd_a20_value, a20_snoop_en;
  logic addr_line20_mask, game_port_chip_select_n, boot_rom_chip_select_n;
  isa_cycle_t isa_cycle;
  decode_t isa_decode;
  logic [3:0] dec_w;
  int n_fail, n_checks, n_pulse, p0, p, cycles;
  // Columns: offset, write, readback, cycle, {game_n, rom_n, port92, block}
  row_t rows [19] = '{
    {8'h52, 8'h20, 8'h20, 3'b101, 24'h000200, 4'b0100}, {8'h52, 8'h20, 8'h20, 3'b111, 24'h000201, 4'b1100},
    {8'h52, 8'h40, 8'h40, 3'b111, 24'h000201, 4'b0100}, {8'h52, 8'h40, 8'h40, 3'b101, 24'h000200, 4'b1100},
    {8'h52, 8'h08, 8'h08, 3'b101, 24'h000092, 4'b1110}, {8'h52, 8'h00, 8'h00, 3'b101, 24'h000092, 4'b1100},
    {8'h52, 8'h00, 8'h00, 3'b100, 24'hfc0000, 4'b1000}, {8'h52, 8'h04, 8'h04, 3'b100, 24'hf00000, 4'b1000},
    {8'h52, 8'h04, 8'h04, 3'b100, 24'hff0000, 4'b1000}, {8'h52, 8'h00, 8'h00, 3'b100, 24'h0f0000, 4'b1000},
    {8'h52, 8'h00, 8'h00, 3'b100, 24'h0e0000, 4'b1100}, {8'h52, 8'h01, 8'h01, 3'b100, 24'h0e0000, 4'b1000},
    {8'h52, 8'h00, 8'h00, 3'b110, 24'hff0000, 4'b1100}, {8'h52, 8'h02, 8'h02, 3'b110, 24'hff0000, 4'b1000},
    {8'h53, 8'h40, 8'h40, 3'b111, 24'h000200, 4'b1101}, {8'h53, 8'h00, 8'h00, 3'b111, 24'h000200, 4'b1100},
    {8'h53, 8'hff, 8'h7f, 3'b101, 24'h000200, 4'b1100}, {8'h60, 8'hff, 8'h00, 3'b101, 24'h000200, 4'b1100},
    {8'h52, 8'h00, 8'h00, 3'b100, 24'hf00000, 4'b1100}};
  logic [7:0] rst_off [6] = '{8'h44, 8'h50, 8'h51, 8'h52, 8'h53, 8'h60};
  logic [7:0] rst_val [6] = '{8'h01, 8'h7b, 8'h40, 8'hf8, 8'h00, 8'h00};
  assign dec_w = {game_port_chip_select_n, boot_rom_chip_select_n, isa_decode.port92_hit, isa_decode.isa_block};
  legacy_isa_bridge_config_regs uut (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reference_clock_in(reference_clock_in),
    .slow_clock_in(slow_clock_in), .slow_clock_pin(slow_clock_pin), .slow_clock_oe(slow_clock_oe),
    .slow_clock(slow_clock), .disk_ctrl_rst(disk_ctrl_rst), .disk_bus_rst(disk_bus_rst), .pci_bus_rst(pci_bus_rst),
    .system_rst_pulse(system_rst_pulse), .warm_reset_seen(warm_reset_seen), .interval_timer_rst(interval_timer_rst),
    .timer_ch1_output(timer_ch1_output), .timer_ch0_output(timer_ch0_output), .timer_ch1_gate(timer_ch1_gate),
    .timer_ch0_gate(timer_ch0_gate), .port61_bit4(port61_bit4), .interrupt_line_zero(interrupt_line_zero),
    .isa_clk(isa_clk), .isa_io_busy_end(isa_io_busy_end), .isa_io_is_16(isa_io_is_16),
    .isa_io_recovering(isa_io_recovering), .kbd_a20_cmd(kbd_a20_cmd), .kbd_a20_value(kbd_a20_value),
    .a20_snoop_en(a20_snoop_en), .addr_line20_mask(addr_line20_mask), .isa_cycle(isa_cycle), .isa_decode(isa_decode),
    .game_port_chip_select_n(game_port_chip_select_n), .boot_rom_chip_select_n(boot_rom_chip_select_n));
  legacy_peripheral_model peer (.mclk(mclk), .sys_rst(sys_rst), .reference_clock_in(reference_clock_in),
    .slow_clock_in(slow_clock_in), .timer_ch0_output(timer_ch0_output), .timer_ch1_output(timer_ch1_output));
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %0t byte got %h expected %h", $time, g, e);
    end
  endtask : chk8
  task automatic chk1(input logic g, input logic e);
    chk8({7'h00, g}, {7'h00, e});
  endtask : chk1
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] r);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 r = reg_rdata;
  endtask : rd
  // Cycles from the second to the third rising edge of the ISA clock
  task automatic isa_period(output int per);
    logic prev;
    int edges;
    per = 0;
    edges = 0;
    prev = isa_clk;
    for (int n = 0; n < 64 && edges < 3; n++) begin
      @(posedge mclk);
      #1;
      if (edges == 2) per++;
      if (isa_clk === 1'b1 && prev === 1'b0) edges++;
      prev = isa_clk;
    end
  endtask : isa_period
  // Cycles between two toggles of the internal slow clock
  task automatic slow_half(output int per);
    logic prev;
    per = 0;
    @(slow_clock_pin);
    #1 prev = slow_clock_pin;
    while (slow_clock_pin === prev && per < 1000) begin
      @(posedge mclk);
      #1 per++;
    end
  endtask : slow_half
  // One ISA clock is two mclk at divisor 001; allow one cycle of load skew
  task automatic recover(input logic w16, input int f);
    int c;
    c = 0;
    @(posedge mclk);
    isa_io_is_16 <= w16;
    isa_io_busy_end <= 1'b1;
    @(posedge mclk);
    isa_io_busy_end <= 1'b0;
    repeat (60) begin
      #1 if (isa_io_recovering === 1'b1) c++;
      @(posedge mclk);
    end
    chk1(c >= 2 * f + 3 && c <= 2 * f + 5, 1'b1);
  endtask : recover
  task automatic kick(input logic kbd);
    @(posedge mclk);
    kbd_a20_cmd <= kbd;
    warm_reset_seen <= !kbd;
    kbd_a20_value <= 1'b1;
    @(posedge mclk);
    kbd_a20_cmd <= 1'b0;
    warm_reset_seen <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
  endtask : kick
  task automatic summarize();
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : summarize
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles++;
    if (system_rst_pulse === 1'b1) n_pulse++;
    if (cycles == 20000) begin
      n_fail++;
      summarize();
    end
  end
  initial begin
    {sys_rst, reg_wr, reg_rd, warm_reset_seen, isa_io_busy_end, isa_io_is_16, kbd_a20_cmd, kbd_a20_value} = 8'h80;
    {reg_addr, reg_wdata, isa_cycle} = '0;
    repeat (8) @(posedge mclk);
    sys_rst <= 1'b0;
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, q);
      chk8(q, rows[i].e);
      @(posedge mclk);
      isa_cycle <= rows[i].c;
      @(posedge mclk);
      #1 chk8({4'h0, dec_w}, {4'h0, rows[i].x});
    end
    // Mid-run reset must bring every register back
    @(posedge mclk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    foreach (rst_off[i]) begin
      rd(rst_off[i], q);
      chk8(q, rst_val[i]);
    end
    chk8({3'h0, timer_ch1_gate, timer_ch0_gate, interval_timer_rst, pci_bus_rst, addr_line20_mask}, 8'h18);
    wr(8'h44, 8'h0e);
    chk8({4'h0, disk_ctrl_rst, disk_bus_rst, pci_bus_rst, interval_timer_rst}, 8'h0e);
    rd(8'h50, q);
    chk8(q, 8'h7b);
    rd(8'h44, q);
    chk8(q, 8'h0f);
    wr(8'h44, 8'h00);
    chk8({5'h00, disk_ctrl_rst, disk_bus_rst, pci_bus_rst}, 8'h00);
    for (int k = 0; k < 4; k++) begin
      wr(8'h44, 8'(k << 4));
      chk1(slow_clock_oe, k == 1);
      chk1(slow_clock, k == 2 ? slow_clock_in : k != 3 && slow_clock_pin);
    end
    chk1(slow_clock, 1'b0);
    slow_half(p);
    chk1(p == 2 * REF_HALF_PERIOD, 1'b1);
    p0 = n_pulse;
    wr(8'h44, 8'h00);
    repeat (3) @(posedge mclk);
    chk8(8'(n_pulse - p0), 8'h00);
    wr(8'h44, 8'h01);
    repeat (3) @(posedge mclk);
    chk8(8'(n_pulse - p0), 8'h01);
    rd(8'h44, q);
    chk8(q, 8'h00);
    wr(8'h50, 8'hd9);
    chk8({5'h00, interval_timer_rst, timer_ch1_gate, timer_ch0_gate}, 8'h05);
    for (int k = 0; k < 8; k++) begin
      if (k == 4) wr(8'h50, 8'h22);
      @(posedge mclk);
      #1 chk1(port61_bit4, timer_ch1_output & (k < 4));
      chk1(interrupt_line_zero, timer_ch0_output & (k < 4));
    end
    chk8({5'h00, interval_timer_rst, timer_ch1_gate, timer_ch0_gate}, 8'h02);
    // Codes 010 and 011 are the ones software uses at 25 and 33 MHz
    for (int k = 1; k < 4; k++) begin
      wr(8'h50, 8'h78 | 8'(k));
      isa_period(p);
      chk8(8'(p), 8'(k + 1));
    end
    wr(8'h50, 8'h78);
    repeat (8) @(posedge mclk);
    #1 chk1(isa_clk, 1'b0);
    wr(8'h50, 8'h79);
    wr(8'h51, 8'h31);
    recover(1'b0, 3);
    recover(1'b1, 1);
    wr(8'h52, 8'h80);
    chk1(a20_snoop_en, 1'b1);
    kick(1'b1);
    chk1(addr_line20_mask, 1'b1);
    wr(8'h52, 8'h90);
    kick(1'b0);
    chk1(addr_line20_mask, 1'b0);
    wr(8'h52, 8'h00);
    kick(1'b1);
    chk8({6'h00, a20_snoop_en, addr_line20_mask}, 8'h00);
    summarize();
  end
endmodule : legacy_isa_bridge_config_regs_tb
`default_nettype wire
